//--- bench/itca_host.sv
// host processor model driving the timer's pin port
`timescale 1ns/10ps
module itca_host (
  // clock
  input wire logic clk_i,
  // pins toward the device
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [1:0] sel_o,
  output logic [7:0] data_o,
  // pins from the device
  input wire logic [7:0] data_i,
  input wire logic data_oe_i
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_o = 2'h0;
    data_o = 8'h00;
  end

  // one whole access at a time, never split by another routine
  // strobe low four clocks, idle five: the two-stage synchroniser plus the output flop need three
  task automatic access(input logic rd, input logic cs,
      input logic [1:0] sel, input logic [7:0] wd,
      output logic [7:0] rdat, output logic oe);
    @(posedge clk_i);
    #1;
    cs_n_o = ~cs;
    sel_o = sel;
    data_o = wd;
    rd_n_o = ~rd;
    wr_n_o = rd;
    repeat (4) @(posedge clk_i);
    #1;
    rdat = data_i;
    oe = data_oe_i;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    data_o = ~wd;  // released bus shows no stale byte
    repeat (5) @(posedge clk_i);
    #1;
  endtask
endmodule

//--- bench/itca_props.sv
// assertion checker for the timer command and count access block
`timescale 1ns/10ps
module itca_props #(
  parameter int unsigned NUM_UNITS = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // host pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic port_sel_hi_i,
  input wire logic port_sel_lo_i,
  input wire logic data_oe_o,
  // counting core side
  input wire logic [NUM_UNITS-1:0] load_done_i,
  input wire logic [NUM_UNITS-1:0] load_strobe_o,
  input wire logic [NUM_UNITS-1:0] program_o,
  input wire logic [NUM_UNITS-1:0][2:0] op_mode_o,
  input wire logic [NUM_UNITS-1:0] decade_count_o,
  input wire logic [NUM_UNITS-1:0] pending_load_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // a selected counter read; window of depths covers synchroniser skew
  logic rd_act;
  assign rd_act = !cs_n_i && !rd_n_i && wr_n_i &&
    ({port_sel_hi_i, port_sel_lo_i} != itca_pkg::PORT_CTRL);

  a_oe_cause: assert property (data_oe_o |-> $past(rd_act, 2) ||
    $past(rd_act, 3) || $past(rd_act, 4))
    else $error("bus driven without a counter read");

  // per-counter relations between control, load and flag outputs
  for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
    a_prog_pends: assert property (program_o[i] |-> pending_load_o[i])
      else $error("control word did not raise pending flag");
    a_load_pends: assert property (load_strobe_o[i] |-> pending_load_o[i])
      else $error("count write did not raise pending flag");
    a_done_clears: assert property (load_done_i[i] ##1
      !(load_strobe_o[i] || program_o[i]) |-> !pending_load_o[i])
      else $error("pending flag survived a load");
    a_mode_legal: assert property (op_mode_o[i] <= 3'h5)
      else $error("mode outside 0 to 5");
    a_mode_held: assert property (!program_o[i] |->
      $stable(op_mode_o[i]) && $stable(decade_count_o[i]))
      else $error("mode changed without a control word");
    a_prog_once: assert property (program_o[i] |=> !program_o[i])
      else $error("program pulse longer than one cycle");
    a_strobe_once: assert property (load_strobe_o[i] |=> !load_strobe_o[i])
      else $error("load pulse longer than one cycle");
  end
endmodule

bind itca_top itca_props #(.NUM_UNITS(NUM_UNITS)) i_itca_props (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .cs_n_i(cs_n_i),
  .rd_n_i(rd_n_i),
  .wr_n_i(wr_n_i),
  .port_sel_hi_i(port_sel_hi_i),
  .port_sel_lo_i(port_sel_lo_i),
  .data_oe_o(data_oe_o),
  .load_done_i(load_done_i),
  .load_strobe_o(load_strobe_o),
  .program_o(program_o),
  .op_mode_o(op_mode_o),
  .decade_count_o(decade_count_o),
  .pending_load_o(pending_load_o)
);

//--- bench/testbench.sv
// self-checking bench for the timer command and count access block
`timescale 1ns/10ps
module testbench;
  logic clk_i;
  logic reset_i;
  logic cs_n, rd_n, wr_n, doe, oe;
  logic [1:0] sel, u;
  logic [7:0] hdat, ddat, rb;
  logic [2:0] wave, done, prog, pend, dec, split;
  logic [2:0][15:0] core, loadr;
  logic [2:0][2:0] mode;
  logic [11:0] rows [8];
  int fail_count, checks;

  itca_top i_itca_top (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .port_sel_hi_i(sel[1]),
    .port_sel_lo_i(sel[0]), .data_i(hdat), .data_o(ddat),
    .data_oe_o(doe), .core_count_i(core), .wave_pin_i(wave),
    .load_done_i(done), .load_register_o(loadr), .load_strobe_o(),
    .write_split_o(split), .program_o(prog), .op_mode_o(mode),
    .decade_count_o(dec), .pending_load_o(pend));
  itca_host i_itca_host (.clk_i(clk_i), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .sel_o(sel), .data_o(hdat), .data_i(ddat),
    .data_oe_i(doe));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    i_itca_host.access(1'b0, 1'b1, s, d, rb, oe);
  endtask

  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    i_itca_host.access(1'b1, 1'b1, s, 8'h00, rb, oe);
    chk({7'h00, oe, rb}, {7'h00, 1'b1, e});
  endtask

  // a load from every core clears every pending flag
  task automatic clear_pend();
    done = 3'h7;
    @(posedge clk_i);
    #1;
    done = 3'h0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(16'(pend), 16'h0000);
  endtask

  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // cuts a hang short
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    conclude();
  end

  initial begin
    // command byte, then decade bit and decoded mode
    rows = '{12'h300, 12'h739, 12'hB42, 12'h37B,
             12'h784, 12'hBBD, 12'h3C2, 12'h7FB};
    reset_i = 1'b1;
    core = '0;
    wave = 3'h0;
    done = 3'h0;
    repeat (4) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    chk(16'({pend, doe}), 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(2'h3, rows[i][11:4]);
      u = rows[i][11:10];
      chk(16'({dec[u], mode[u]}), 16'(rows[i][3:0]));
      chk(16'(pend[u]), 16'h0001);
    end
    // latch, repeat latch, interleaved two-byte reads and writes
    clear_pend();
    core[0] = 16'h1234;  // count taken by the first latch
    wr(2'h3, 8'h00);
    core[0] = 16'h5678;
    wr(2'h3, 8'h00);
    rd(2'h0, 8'h34);
    wr(2'h0, 8'hCD);
    wr(2'h3, 8'h00);
    rd(2'h0, 8'h12);
    wr(2'h0, 8'hAB);
    chk(loadr[0], 16'hABCD);
    chk(16'({pend[0], mode[0]}), 16'h000A);
    rd(2'h0, 8'h78);
    rd(2'h0, 8'h56);
    // read-back of count and status on counters 2 and 0
    clear_pend();
    core[0] = 16'h4321;
    core[2] = 16'h0A0B;
    wave = 3'h5;
    wr(2'h3, 8'hCA); // reserved bit zero
    core[0] = 16'h0000;
    core[2] = 16'h0000;
    wave = 3'h0;
    rd(2'h2, 8'hBB);
    rd(2'h2, 8'h0B);
    rd(2'h2, 8'h0A);
    rd(2'h0, 8'hBC);
    rd(2'h0, 8'h21);
    rd(2'h0, 8'h43);
    rd(2'h0, 8'h00);
    // one-byte formats and a latch dropped by reprogramming
    core[1] = 16'hEF10;
    wr(2'h3, 8'h60);
    wr(2'h1, 8'h9A);
    chk(loadr[1], 16'h9A00);
    rd(2'h1, 8'hEF);
    wr(2'h3, 8'h40);
    core[1] = 16'h2301;
    wr(2'h3, 8'h50);
    rd(2'h1, 8'h01);
    wr(2'h1, 8'h77);
    chk(loadr[1], 16'h0077);
    // half-written pair abandoned by a control word restarts low
    wr(2'h2, 8'h11);
    chk(16'(split[2]), 16'h0001);
    wr(2'h3, 8'hB0);
    chk(16'({split[2], mode[2]}), 16'h0000);
    wr(2'h2, 8'h22);
    wr(2'h2, 8'h33);
    chk(loadr[2], 16'h3322);
    // status-only read-back leaves the count live
    wr(2'h3, 8'hE4);
    core[1] = 16'h4455;
    rd(2'h1, 8'h50);
    rd(2'h1, 8'h55);
    // refused accesses
    i_itca_host.access(1'b1, 1'b1, 2'h3, 8'h00, rb, oe);
    chk(16'(oe), 16'h0000);
    i_itca_host.access(1'b0, 1'b0, 2'h3, 8'h10, rb, oe);
    chk(16'(mode[0]), 16'h0002);
    // mid-run reset brings every output back to idle
    reset_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    chk(16'({pend, dec, split, doe}), 16'h0000);
    chk({ddat, 5'h00, prog}, 16'h0000);
    chk(loadr[2], 16'h0000);
    chk(16'(mode), 16'h0000);
    conclude();
  end
endmodule

//--- verilog/itca_pkg.sv
// shared constants and types for the timer command and count access block
package itca_pkg;

  // number of counters served by the access logic
  localparam int unsigned NUM_UNITS = 3;

  // select-line code of the command register port
  localparam logic [1:0] PORT_CTRL = 2'h3;

  // command byte fields
  localparam int unsigned UNIT_MSB = 7;
  localparam int unsigned UNIT_LSB = 6;
  localparam int unsigned ORDER_MSB = 5;
  localparam int unsigned ORDER_LSB = 4;
  localparam int unsigned OPK_MSB = 3;
  localparam int unsigned OPK_LSB = 1;
  localparam int unsigned OPK_MID = 2;
  localparam int unsigned DEC_BIT = 0;
  localparam int unsigned CW_KEEP_MSB = 5;

  // read-back command fields (count/status bits are active low)
  localparam int unsigned RB_CNT_N = 5;
  localparam int unsigned RB_STS_N = 4;
  localparam int unsigned RB_PICK_LSB = 1;

  // status byte fields
  localparam int unsigned STS_WAVE = 7;
  localparam int unsigned STS_PEND = 6;

  // unit_pick code that marks a read-back command
  localparam logic [1:0] UNIT_READBACK = 2'h3;

  // byte_order encodings
  typedef enum logic [1:0] {
    ORD_LATCH = 2'h0,
    ORD_LO = 2'h1,
    ORD_HI = 2'h2,
    ORD_BOTH = 2'h3
  } itca_order_t;

  // reset values; the real part powers up undefined
  localparam logic [5:0] CW_RST = 6'h10;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] STROBE_IDLE = 3'h7;
  localparam logic [9:0] BUS_IDLE = 10'h000;

  // op_kind to mode number; top bit is ignored for modes 2 and 3
  function automatic logic [2:0] itca_mode_decode(input logic [2:0] k);
    logic [2:0] m;
    m = k;
    if (k[1]) begin
      m = {1'b0, k[1:0]};
    end
    return m;
  endfunction

endpackage

//--- verilog/itca_rdsel.sv
// picks the byte a counter returns on a read
`timescale 1ns/10ps
module itca_rdsel (
  // read sequencing state
  input wire logic [1:0] order_i,
  input wire logic rd_ptr_i,
  // latched status
  input wire logic sts_held_i,
  input wire logic [7:0] sts_byte_i,
  // latched and live count
  input wire logic cnt_held_i,
  input wire logic [15:0] hold_i,
  input wire logic [15:0] core_i,
  // byte to drive
  output logic [7:0] byte_o
);

  logic [15:0] value;

  // status first, then frozen count, else live count
  always_comb begin
    value = cnt_held_i ? hold_i : core_i;
    byte_o = value[7:0];
    if (sts_held_i) begin
      byte_o = sts_byte_i;
    end else begin
      unique case (order_i)
        itca_pkg::ORD_HI: byte_o = value[15:8];
        itca_pkg::ORD_BOTH: byte_o = rd_ptr_i ? value[15:8] : value[7:0];
        default: byte_o = value[7:0];
      endcase
    end
  end

endmodule

//--- verilog/itca_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module itca_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // asynchronous pins and their synchronised copy
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
  end

  // both stages reset to the idle pin level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

//--- verilog/itca_top.sv
// command decode and count access for a three-counter interval timer
`timescale 1ns/10ps
// Function
// - commands only written to select code three
// - top two bits pick counter or read-back
// - byte_order: latch, low, high, low-then-high
// - op_kind decoded, top bit ignored modes 2-3
// - decade bit selects binary or four-decade count
// - new count anytime, mode kept
// - byte_order zero means latch command
// - hold latch freezes count until fully read
// - each counter has its own hold state
// - latch leaves mode and counting alone
// - repeated latch ignored while still held
// - two-byte reads may be interleaved elsewhere
// - separate read and write byte pointers
// - read-back picks counters via bits 3..1
// - bit5 low latches count, bit4 status
// - read-back exposes count, mode, pin, pending
// - select lines qualified by chip select, strobes
// - status: pin bit7, pending bit6, control 5..0
// - status read first, then latched count
// - pending flag set by program/write, cleared load
module itca_top #(
  parameter int unsigned NUM_UNITS = itca_pkg::NUM_UNITS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // host port pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic port_sel_hi_i,
  input wire logic port_sel_lo_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // from the counting cores
  input wire logic [NUM_UNITS-1:0][15:0] core_count_i,
  input wire logic [NUM_UNITS-1:0] wave_pin_i,
  input wire logic [NUM_UNITS-1:0] load_done_i,
  // to the counting cores
  output logic [NUM_UNITS-1:0][15:0] load_register_o,
  output logic [NUM_UNITS-1:0] load_strobe_o,
  output logic [NUM_UNITS-1:0] write_split_o,
  output logic [NUM_UNITS-1:0] program_o,
  output logic [NUM_UNITS-1:0][2:0] op_mode_o,
  output logic [NUM_UNITS-1:0] decade_count_o,
  output logic [NUM_UNITS-1:0] pending_load_o
);

  // address decode is fixed to three counters plus command port
  if (NUM_UNITS != itca_pkg::NUM_UNITS) begin : g_bad_units
    $error("itca_top supports exactly three counters");
  end

  // synchronised pins
  logic [2:0] strobe_s;
  logic [9:0] bus_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [1:0] sel_s;
  logic [7:0] din_s;

  // access tracking
  logic wr_sel_q;
  logic wr_sel_d;
  logic rd_sel_q;
  logic rd_sel_d;
  logic [1:0] wr_addr_q;
  logic [1:0] wr_addr_d;
  logic [7:0] wr_data_q;
  logic [7:0] wr_data_d;
  logic [1:0] rd_addr_q;
  logic [1:0] rd_addr_d;
  logic [7:0] dout_q;
  logic [7:0] dout_d;
  logic doe_q;
  logic doe_d;

  // decoded events
  logic wr_now;
  logic rd_now;
  logic wr_take;
  logic rd_end;
  logic ctrl_take;
  logic is_rb;
  logic [1:0] cmd_unit;
  logic [1:0] cmd_order;
  logic [NUM_UNITS-1:0] cnt_wr;
  logic [NUM_UNITS-1:0] rd_done;
  logic [NUM_UNITS-1:0] prog;
  logic [NUM_UNITS-1:0] latch_cmd;
  logic [NUM_UNITS-1:0] rb_cnt;
  logic [NUM_UNITS-1:0] rb_sts;
  logic [NUM_UNITS-1:0][7:0] rd_byte;

  // pins cross in through two flops before any decode
  itca_sync #(
    .WIDTH(3),
    .RST_VAL(itca_pkg::STROBE_IDLE)
  ) u_sync_strobe (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i({cs_n_i, rd_n_i, wr_n_i}),
    .sync_o(strobe_s)
  );

  itca_sync #(
    .WIDTH(10),
    .RST_VAL(itca_pkg::BUS_IDLE)
  ) u_sync_bus (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i({port_sel_hi_i, port_sel_lo_i, data_i}),
    .sync_o(bus_s)
  );

  assign cs_n_s = strobe_s[2];
  assign rd_n_s = strobe_s[1];
  assign wr_n_s = strobe_s[0];
  assign sel_s = bus_s[9:8];
  assign din_s = bus_s[7:0];

  // strobes only count while chip select is low
  assign wr_now = !cs_n_s && !wr_n_s && rd_n_s;
  assign rd_now = !cs_n_s && !rd_n_s && wr_n_s &&
                  (sel_s != itca_pkg::PORT_CTRL);

  // a write commits when its strobe ends, using the last sampled
  // address and data, so slow data settling on the pins is harmless
  assign wr_take = wr_sel_q && !wr_now;
  assign rd_end = rd_sel_q && !rd_now;

  // command register decode
  assign ctrl_take = wr_take && (wr_addr_q == itca_pkg::PORT_CTRL);
  assign cmd_unit = wr_data_q[itca_pkg::UNIT_MSB:itca_pkg::UNIT_LSB];
  assign cmd_order = wr_data_q[itca_pkg::ORDER_MSB:itca_pkg::ORDER_LSB];
  assign is_rb = (cmd_unit == itca_pkg::UNIT_READBACK);

  // per-counter event fan-out
  always_comb begin
    for (int k = 0; k < NUM_UNITS; k++) begin
      cnt_wr[k] = wr_take && (wr_addr_q == 2'(k));
      rd_done[k] = rd_end && (rd_addr_q == 2'(k));
      prog[k] = ctrl_take && !is_rb && (cmd_unit == 2'(k)) &&
                (cmd_order != itca_pkg::ORD_LATCH);
      latch_cmd[k] = ctrl_take && !is_rb && (cmd_unit == 2'(k)) &&
                     (cmd_order == itca_pkg::ORD_LATCH);
      rb_cnt[k] = ctrl_take && is_rb &&
                  !wr_data_q[itca_pkg::RB_CNT_N] &&
                  wr_data_q[itca_pkg::RB_PICK_LSB + k];
      rb_sts[k] = ctrl_take && is_rb &&
                  !wr_data_q[itca_pkg::RB_STS_N] &&
                  wr_data_q[itca_pkg::RB_PICK_LSB + k];
    end
  end

  // access tracking and read data next values
  always_comb begin
    wr_sel_d = wr_now;
    rd_sel_d = rd_now;
    wr_addr_d = wr_now ? sel_s : wr_addr_q;
    wr_data_d = wr_now ? din_s : wr_data_q;
    rd_addr_d = rd_now ? sel_s : rd_addr_q;
    // command port and idle bus are never driven
    doe_d = rd_now;
    dout_d = dout_q;
    if (rd_now) begin
      dout_d = itca_pkg::BYTE_RST;
      for (int k = 0; k < NUM_UNITS; k++) begin
        if (sel_s == 2'(k)) begin
          dout_d = rd_byte[k];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_sel_q <= 1'b0;
      rd_sel_q <= 1'b0;
      wr_addr_q <= itca_pkg::PORT_CTRL;
      wr_data_q <= itca_pkg::BYTE_RST;
      rd_addr_q <= itca_pkg::PORT_CTRL;
      dout_q <= itca_pkg::BYTE_RST;
      doe_q <= 1'b0;
    end else begin
      wr_sel_q <= wr_sel_d;
      rd_sel_q <= rd_sel_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      rd_addr_q <= rd_addr_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
    end
  end

  assign data_o = dout_q;
  assign data_oe_o = doe_q;

  // one independent access channel per counter
  for (genvar i = 0; i < NUM_UNITS; i++) begin : g_unit
    logic [5:0] cw_q; // control bits 5..0 as last written
    logic [5:0] cw_d;
    logic [2:0] mode_q;
    logic [2:0] mode_d;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    logic cnt_held_q;
    logic cnt_held_d;
    logic sts_held_q;
    logic sts_held_d;
    logic [7:0] sts_q;
    logic [7:0] sts_d;
    logic rd_ptr_q;
    logic rd_ptr_d;
    logic wr_ptr_q;
    logic wr_ptr_d;
    logic [15:0] load_q;
    logic [15:0] load_d;
    logic null_q;
    logic null_d;
    logic strobe_q;
    logic strobe_d;
    logic split_q;
    logic split_d;
    logic prog_q;
    logic prog_d;
    logic [1:0] order;

    assign order = cw_q[itca_pkg::ORDER_MSB:itca_pkg::ORDER_LSB];

    // channel next state; later assignments take priority
    always_comb begin
      cw_d = cw_q;
      mode_d = mode_q;
      hold_d = hold_q;
      cnt_held_d = cnt_held_q;
      sts_held_d = sts_held_q;
      sts_d = sts_q;
      rd_ptr_d = rd_ptr_q;
      wr_ptr_d = wr_ptr_q;
      load_d = load_q;
      split_d = split_q;
      strobe_d = 1'b0;
      prog_d = 1'b0;
      null_d = null_q;
      // transfer into the core clears pending; any set below wins
      if (load_done_i[i]) begin
        null_d = 1'b0;
      end
      // read advance: status first, then one or two count bytes
      if (rd_done[i]) begin
        if (sts_held_q) begin
          sts_held_d = 1'b0;
        end else if (order == itca_pkg::ORD_BOTH && !rd_ptr_q) begin
          rd_ptr_d = 1'b1;
        end else begin
          rd_ptr_d = 1'b0;
          cnt_held_d = 1'b0;
        end
      end
      // count latch; a second latch before the read is dropped
      if ((latch_cmd[i] || rb_cnt[i]) && !cnt_held_q) begin
        hold_d = core_count_i[i];
        cnt_held_d = 1'b1;
      end
      // status latch snapshots pin, pending flag and control bits
      if (rb_sts[i] && !sts_held_q) begin
        sts_d = {wave_pin_i[i], null_q, cw_q};
        sts_held_d = 1'b1;
      end
      // count write in the programmed byte format, mode untouched
      if (cnt_wr[i]) begin
        unique case (order)
          itca_pkg::ORD_LO: begin
            load_d = {itca_pkg::BYTE_RST, wr_data_q};
            strobe_d = 1'b1;
            null_d = 1'b1;
          end
          itca_pkg::ORD_HI: begin
            load_d = {wr_data_q, itca_pkg::BYTE_RST};
            strobe_d = 1'b1;
            null_d = 1'b1;
          end
          default: begin
            if (!wr_ptr_q) begin
              load_d = {load_q[15:8], wr_data_q};
              wr_ptr_d = 1'b1;
              split_d = 1'b1;
            end else begin
              load_d = {wr_data_q, load_q[7:0]};
              wr_ptr_d = 1'b0;
              split_d = 1'b0;
              strobe_d = 1'b1;
              null_d = 1'b1;
            end
          end
        endcase
      end
      // control word: new format, pointers home, latches dropped
      if (prog[i]) begin
        cw_d = wr_data_q[itca_pkg::CW_KEEP_MSB:0];
        mode_d = itca_pkg::itca_mode_decode(
          wr_data_q[itca_pkg::OPK_MSB:itca_pkg::OPK_LSB]);
        rd_ptr_d = 1'b0;
        wr_ptr_d = 1'b0;
        cnt_held_d = 1'b0;
        sts_held_d = 1'b0;
        split_d = 1'b0;
        null_d = 1'b1;
        prog_d = 1'b1;
      end
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        cw_q <= itca_pkg::CW_RST;
        mode_q <= itca_pkg::MODE_RST;
        hold_q <= itca_pkg::WORD_RST;
        cnt_held_q <= 1'b0;
        sts_held_q <= 1'b0;
        sts_q <= itca_pkg::BYTE_RST;
        rd_ptr_q <= 1'b0;
        wr_ptr_q <= 1'b0;
        load_q <= itca_pkg::WORD_RST;
        null_q <= 1'b0;
        strobe_q <= 1'b0;
        split_q <= 1'b0;
        prog_q <= 1'b0;
      end else begin
        cw_q <= cw_d;
        mode_q <= mode_d;
        hold_q <= hold_d;
        cnt_held_q <= cnt_held_d;
        sts_held_q <= sts_held_d;
        sts_q <= sts_d;
        rd_ptr_q <= rd_ptr_d;
        wr_ptr_q <= wr_ptr_d;
        load_q <= load_d;
        null_q <= null_d;
        strobe_q <= strobe_d;
        split_q <= split_d;
        prog_q <= prog_d;
      end
    end

    // byte this counter would return now
    itca_rdsel u_rdsel (
      .order_i(order),
      .rd_ptr_i(rd_ptr_q),
      .sts_held_i(sts_held_q),
      .sts_byte_i(sts_q),
      .cnt_held_i(cnt_held_q),
      .hold_i(hold_q),
      .core_i(core_count_i[i]),
      .byte_o(rd_byte[i])
    );

    // core-facing outputs straight from channel flops
    assign load_register_o[i] = load_q;
    assign load_strobe_o[i] = strobe_q;
    assign write_split_o[i] = split_q;
    assign program_o[i] = prog_q;
    assign op_mode_o[i] = mode_q;
    assign decade_count_o[i] = cw_q[itca_pkg::DEC_BIT];
    assign pending_load_o[i] = null_q;
  end

endmodule
